// *** include/ddc_pkg.sv ***
// constants and types shared by the daisy-chain serial port
package ddc_pkg;
    // word layout: result in the upper bits, status bits below it
    localparam int RES_BITS      = 18;
    localparam int STAT_BITS     = 6;
    localparam int WORD_BITS     = 24;
    localparam int WORD_MSB      = 23;
    localparam logic [4:0] LEN_PLAIN  = 5'h12;   // 18 clocks per device
    localparam logic [4:0] LEN_STATUS = 5'h18;   // 24 clocks per device
    localparam logic [4:0] CNT_SAT    = 5'h1f;
    // register write path: command byte then data byte
    localparam int BYTE_BITS     = 8;
    localparam int WR_BITS       = 16;
    localparam logic [4:0] WR_FULL    = 5'h10;
    localparam logic [4:0] WR_PASS    = 5'h08;   // one byte of delay per device
    localparam logic [7:0] CFG_WR_CMD = 8'h14;
    localparam int OVL_BIT       = 1;
    localparam logic OVL_RST     = 1'b0;         // overlapped readout off after reset
    // conversion time
    localparam int T_CONV_NS     = 290;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_CYC_DEF  = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CNT_BITS = 8;
    // conversion sequencer states
    typedef enum logic [2:0] {
        DDC_IDLE = 3'b001,
        DDC_CONV = 3'b010,
        DDC_READ = 3'b100
    } ddc_state_t;
endpackage

// *** include/ddc_link_if.sv ***
// signals between the system-clock core and the serial-clock link logic
interface ddc_link_if;
    logic [23:0] word;
    logic [4:0]  word_len;
    logic [23:0] in_sr;
    logic [15:0] wr_sr;
    logic [4:0]  wr_cnt;
    logic [4:0]  fall_cnt;
    logic        obit;
    logic        fall_seen;
    logic        wobit;
    modport core (
        output word, word_len,
        input  in_sr, wr_sr, wr_cnt, fall_cnt, obit, fall_seen, wobit
    );
    modport link (
        input  word, word_len,
        output in_sr, wr_sr, wr_cnt, fall_cnt, obit, fall_seen, wobit
    );
endinterface

// *** core/ddc_link.sv ***
// serial-clock side: input shift register, result shifter, write pass-through
module ddc_link (
    input  wire logic i_sck,
    input  wire logic i_rst_n,
    input  wire logic i_convert_strobe,
    input  wire logic i_chain_serial_input,
    ddc_link_if.link  lk
);
    typedef struct packed {
        logic [23:0] in_sr;
        logic [15:0] wr_sr;
        logic [4:0]  wr_cnt;
        logic        strb_seen;
    } ddc_rise_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic       obit;
        logic       seen;
    } ddc_fall_t;

    ddc_rise_t r;
    ddc_rise_t next_r;
    ddc_fall_t f;
    ddc_fall_t next_f;
    logic      wobit;
    logic      next_wobit;

    // rising edge: sample the chain input
    always_comb
    begin
        next_r = r;
        // [R9] input sampled on rise
        next_r.in_sr = {r.in_sr[22:0], i_chain_serial_input};
        next_r.strb_seen = i_convert_strobe;
        if (!i_convert_strobe)
        begin
            next_r.wr_sr = {r.wr_sr[14:0], i_chain_serial_input};
            if (r.strb_seen)
                next_r.wr_cnt = 5'h01;           // first edge of a new write
            else if (r.wr_cnt != ddc_pkg::WR_FULL)
                next_r.wr_cnt = r.wr_cnt + 5'h01;
        end
    end

    // link reset is asynchronous: this clock stands still outside frames
    always_ff @(posedge i_sck or negedge i_rst_n)
    begin
        if (!i_rst_n)
            r <= '0;
        else
            r <= next_r;
    end

    // falling edge: own word first, then the upstream devices' bits
    always_comb
    begin
        next_f = f;
        next_f.seen = 1'b1;
        if (f.cnt != ddc_pkg::CNT_SAT)
            next_f.cnt = f.cnt + 5'h01;
        // [R8] [R17] next word bit
        if (next_f.cnt < lk.word_len)
            next_f.obit = lk.word[5'd23 - next_f.cnt];
        // [R18] then pass upstream data
        else
            next_f.obit = r.in_sr[lk.word_len - 5'h01];
    end

    // readout state ends with the frame: cleared while the strobe is low
    always_ff @(negedge i_sck or negedge i_convert_strobe or negedge i_rst_n)
    begin
        if (!i_rst_n || !i_convert_strobe)
            f <= '0;
        else
            f <= next_f;
    end

    // [R3] write pass-through low until a byte is in
    assign next_wobit = (r.wr_cnt >= ddc_pkg::WR_PASS) ? r.wr_sr[7] : 1'b0;

    // pass-through bit, cleared while the strobe is high so the idle output is low
    always_ff @(negedge i_sck or posedge i_convert_strobe or negedge i_rst_n)
    begin
        if (!i_rst_n || i_convert_strobe)
            wobit <= 1'b0;
        else
            wobit <= next_wobit;
    end

    // state seen by the core
    assign lk.in_sr     = r.in_sr;
    assign lk.wr_sr     = r.wr_sr;
    assign lk.wr_cnt    = r.wr_cnt;
    assign lk.fall_cnt  = f.cnt;
    assign lk.obit      = f.obit;
    assign lk.fall_seen = f.seen;
    assign lk.wobit     = wobit;
endmodule

// *** core/ddc_port.sv ***
// daisy-chain serial port of an 18-bit converter: conversion, readout, register write
//
// Functional notes
// [R1] host clears overlapped-readout enable before using the chain
// [R2] overlapped readout comes up disabled after reset
// [R3] serial output low while serial input and strobe are both low; once a byte is in the code passes the input on one byte late
// [R4] strobe rise starts conversion; serial output stays low meanwhile
// [R5] host holds serial input and clock low when strobe rises
// [R6] host keeps strobe high through conversion and readback
// [R7] at conversion end the result MSB appears on the serial output
// [R8] remaining result bits shift out on each later clock fall
// [R9] serial input sampled into shift register on every clock rise
// [R10] without status bits host gives 18 clocks per device
// [R11] with status bits host gives 24 clocks per device
// [R12] output bits stay valid over both clock edges; the code changes them on the clock fall and holds them only over the rise
// [R13] register writes shift in with strobe low on four wires
// [R14] broadcast write uses 8 times (N plus 1) clocks
// [R15] per-device writes go furthest first, nearest with 16 clocks
// [R16] no register readback through the chain
// [R17] status bits follow the result on falls 19 to 24; the code puts them out on falls 18 to 23
// [R18] device acts as 18- or 24-bit shift register in the chain
module ddc_port #(
    parameter int CONV_CYC = ddc_pkg::CONV_CYC_DEF
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_sck,
    input  wire logic        i_convert_strobe,
    input  wire logic        i_chain_serial_input,
    input  wire logic [17:0] i_conv_result,
    input  wire logic [5:0]  i_conv_status,
    input  wire logic        i_status_en,
    output logic             o_chain_serial_output,
    output logic             o_conv_start,
    output logic             o_cfg_valid,
    output logic [7:0]       o_cfg_cmd,
    output logic [7:0]       o_cfg_data,
    output logic             o_overlap_en
);
    localparam int CONV_M1 = CONV_CYC - 1;

    // elaboration check on the conversion count
    if (CONV_CYC < 1 || CONV_CYC > 255)
    begin : g_bad_conv
        $error("conversion count must lie in 1..255");
    end

    typedef struct packed {
        ddc_pkg::ddc_state_t state;
        logic                strb_m;
        logic                strb_s;
        logic                strb_d;
        logic [7:0]          cnt;
        logic [23:0]         word;
        logic [4:0]          word_len;
        logic                done;
        logic                conv_start;
        logic                cfg_valid;
        logic [7:0]          cfg_cmd;
        logic [7:0]          cfg_data;
        logic                overlap;
    } ddc_sys_t;

    localparam ddc_sys_t SYS_RST = '{
        state:      ddc_pkg::DDC_IDLE,
        strb_m:     1'b0,
        strb_s:     1'b0,
        strb_d:     1'b0,
        cnt:        8'h00,
        word:       24'h000000,
        word_len:   ddc_pkg::LEN_PLAIN,
        done:       1'b0,
        conv_start: 1'b0,
        cfg_valid:  1'b0,
        cfg_cmd:    8'h00,
        cfg_data:   8'h00,
        overlap:    ddc_pkg::OVL_RST
    };

    ddc_sys_t   st;
    ddc_sys_t   next_st;
    ddc_link_if lk ();
    logic       strobe_rise;

    // serial-clock side
    ddc_link u_link (
        .i_sck                (i_sck),
        .i_rst_n              (i_rst_n),
        .i_convert_strobe     (i_convert_strobe),
        .i_chain_serial_input (i_chain_serial_input),
        .lk                   (lk)
    );

    // strobe edge seen after the two-stage synchroniser
    assign strobe_rise = st.strb_s && !st.strb_d;

    // conversion sequencer and register write capture
    always_comb
    begin
        next_st = st;
        next_st.strb_m = i_convert_strobe;
        next_st.strb_s = st.strb_m;
        next_st.strb_d = st.strb_s;
        next_st.conv_start = 1'b0;
        next_st.cfg_valid = 1'b0;
        // readout word is meaningless once the strobe falls
        if (!st.strb_s)
            next_st.done = 1'b0;
        unique case (st.state)
            ddc_pkg::DDC_IDLE:
            begin
                if (strobe_rise)
                begin
                    // [R4] strobe rise starts conversion
                    next_st.state = ddc_pkg::DDC_CONV;
                    next_st.cnt = 8'(CONV_M1);
                    next_st.conv_start = 1'b1;
                    next_st.done = 1'b0;
                    // [R17] word length picked per frame
                    next_st.word_len = i_status_en ? ddc_pkg::LEN_STATUS
                                                   : ddc_pkg::LEN_PLAIN;
                    // sck is idle here, so the write shifter is stable
                    if (lk.wr_cnt >= ddc_pkg::WR_FULL)
                    begin
                        next_st.cfg_valid = 1'b1;
                        next_st.cfg_cmd = lk.wr_sr[15:8];
                        next_st.cfg_data = lk.wr_sr[7:0];
                        // [R16] only writes act, nothing is read back
                        if (lk.wr_sr[15:8] == ddc_pkg::CFG_WR_CMD)
                            next_st.overlap = lk.wr_sr[ddc_pkg::OVL_BIT];
                    end
                end
            end
            ddc_pkg::DDC_CONV:
            begin
                if (!st.strb_s)
                    next_st.state = ddc_pkg::DDC_IDLE;   // strobe dropped early
                else if (st.cnt == 8'h00)
                begin
                    // [R7] result ready, MSB goes out
                    next_st.state = ddc_pkg::DDC_READ;
                    next_st.done = 1'b1;
                    next_st.word = {i_conv_result, i_conv_status};
                end
                else
                    next_st.cnt = st.cnt - 8'h01;
            end
            ddc_pkg::DDC_READ:
            begin
                if (!st.strb_s)
                    next_st.state = ddc_pkg::DDC_IDLE;
            end
            default:
                next_st.state = ddc_pkg::DDC_IDLE;
        endcase
    end

    // [R2] sync reset to defaults
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
            st <= SYS_RST;
        else
            st <= next_st;
    end

    // word handed to the serial-clock side, stable through readout
    assign lk.word     = st.word;
    assign lk.word_len = st.word_len;

    // [R3] [R4] [R12] pin select: write path, low while busy, else shifter
    assign o_chain_serial_output = !i_convert_strobe ? lk.wobit :
                                   !st.done          ? 1'b0 :
                                   lk.fall_seen      ? lk.obit : st.word[23];

    // register-held outputs
    assign o_conv_start = st.conv_start;
    assign o_cfg_valid  = st.cfg_valid;
    assign o_cfg_cmd    = st.cfg_cmd;
    assign o_cfg_data   = st.cfg_data;
    assign o_overlap_en = st.overlap;

    // checks on the system-clock side
    sequence strobe_rise_s;
        st.state == ddc_pkg::DDC_IDLE && st.strb_s && !st.strb_d;
    endsequence

    sequence conv_body_s;
        (st.state == ddc_pkg::DDC_CONV && !st.done) throughout (##CONV_M1 1'b1);
    endsequence

    // [R2] overlap off after reset
    reset_overlap_a: assert property (  // [R2]
        @(posedge i_clk_sys) !i_rst_n |=> !o_overlap_en)
        else $error("overlapped readout not cleared by reset");

    // [R4] conversion starts on strobe rise
    conv_start_a: assert property (  // [R4]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        strobe_rise_s |=> o_conv_start && st.state == ddc_pkg::DDC_CONV && !st.done)
        else $error("strobe rise did not start a conversion");

    // [R7] result out after the conversion time
    conv_time_a: assert property (  // [R7]
        @(posedge i_clk_sys) disable iff (!i_rst_n || !st.strb_s)
        strobe_rise_s |=> conv_body_s ##1 (st.done && st.state == ddc_pkg::DDC_READ))
        else $error("result not presented after the conversion time");

    // [R7] MSB loaded from the result
    msb_load_a: assert property (  // [R7]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(st.done) |-> st.word[23:6] == $past(i_conv_result))
        else $error("presented word differs from the conversion result");

    // [R17] word length follows status enable
    len_pick_a: assert property (  // [R17]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_conv_start) |-> st.word_len ==
            ($past(i_status_en) ? ddc_pkg::LEN_STATUS : ddc_pkg::LEN_PLAIN))
        else $error("word length does not follow status enable");

    // [R16] other commands leave the overlap enable unchanged
    no_readback_a: assert property (  // [R16]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_cfg_valid && o_cfg_cmd != ddc_pkg::CFG_WR_CMD) |-> $stable(o_overlap_en))
        else $error("non-write command altered configuration");

    // checks on the serial-clock side
    // [R9] input shift on rise
    shift_in_a: assert property (  // [R9]
        @(posedge i_sck) disable iff (!i_rst_n)
        1'b1 |=> lk.in_sr == {$past(lk.in_sr[22:0]), $past(i_chain_serial_input)})
        else $error("serial input not shifted in on the rising edge");

    // [R8] result bit per fall
    result_out_a: assert property (  // [R8]
        @(negedge i_sck) disable iff (!i_rst_n || !i_convert_strobe)
        (lk.fall_cnt != 5'h00 && lk.fall_cnt < lk.word_len)
            |-> lk.obit == lk.word[5'd23 - lk.fall_cnt])
        else $error("result bit out of order on falling edge");

    // [R17] second status bit after the result, on fall 19
    status_out_a: assert property (  // [R17]
        @(negedge i_sck) disable iff (!i_rst_n || !i_convert_strobe)
        (lk.word_len == ddc_pkg::LEN_STATUS && lk.fall_cnt == 5'h12)
            |=> lk.fall_cnt == 5'h13 && lk.obit == lk.word[4])
        else $error("status bits do not follow the result");

    // [R18] upstream bits delayed by one word
    pass_thru_a: assert property (  // [R18]
        @(negedge i_sck) disable iff (!i_rst_n || !i_convert_strobe)
        (lk.fall_cnt > lk.word_len && lk.fall_cnt != ddc_pkg::CNT_SAT)
            |-> lk.obit == $past(lk.in_sr[lk.word_len - 5'h01]))
        else $error("upstream data not passed after own word");

    // [R3] write path quiet before a byte is in
    wr_quiet_a: assert property (  // [R3]
        @(negedge i_sck) disable iff (!i_rst_n || i_convert_strobe)
        (lk.wr_cnt < ddc_pkg::WR_PASS) |=> !lk.wobit)
        else $error("serial output driven high before a byte was shifted");
endmodule

// *** sim/ddc_host.sv ***
// host model: conversion strobe, serial clock and upstream chain data
module ddc_host (
    input  wire logic i_clk_sys,
    input  wire logic i_chain_serial_output,
    output logic      o_sck,
    output logic      o_convert_strobe,
    output logic      o_chain_serial_input
);
    timeunit 1ns;
    timeprecision 100ps;

    logic seen [0:48];
    int   skew;

    // idle levels: clock stands still low outside frames
    initial
    begin
        o_sck = 1'b0;
        o_convert_strobe = 1'b0;
        o_chain_serial_input = 1'b0;
        skew = 0;
    end

    // strobe held at a level until told otherwise
    task automatic strobe(input logic v);
        @(posedge i_clk_sys);
        #1 o_convert_strobe = v;
    endtask

    // n clocks, input bits msb first, output taken after each fall
    task automatic clocks(input int n, input logic [47:0] bits);
        @(posedge i_clk_sys);
        #4 seen[0] = i_chain_serial_output;
        for (int k = 1; k <= n; k++)
        begin
            o_chain_serial_input = bits[n-k];
            #2 o_sck = 1'b1;
            // bit must still stand after the rise
            #1 if (i_chain_serial_output !== seen[k-1]) skew++;
            #2 o_sck = 1'b0;
            #1 seen[k] = i_chain_serial_output;
        end
        // input and clock low before any strobe rise
        o_chain_serial_input = 1'b0;
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the daisy-chain serial port
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CONV = 2;
    logic        clk;
    logic        rst_n;
    logic        sck;
    logic        strobe;
    logic        chain_serial_input;
    logic        chain_serial_output;
    logic        start;
    logic        cfg_valid;
    logic        ovl;
    logic        st_en;
    logic [17:0] res;
    logic [5:0]  stat;
    logic [7:0]  cmd;
    logic [7:0]  data;
    logic [7:0]  wr_tail;
    int          bad_count;
    int          total_checks;

    ddc_host host_u (.i_clk_sys(clk), .i_chain_serial_output(chain_serial_output), .o_sck(sck),
                     .o_convert_strobe(strobe), .o_chain_serial_input(chain_serial_input));

    ddc_port #(.CONV_CYC(CONV)) dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_sck(sck),
        .i_convert_strobe(strobe), .i_chain_serial_input(chain_serial_input), .i_conv_result(res),
        .i_conv_status(stat), .i_status_en(st_en), .o_chain_serial_output(chain_serial_output),
        .o_conv_start(start), .o_cfg_valid(cfg_valid), .o_cfg_cmd(cmd),
        .o_cfg_data(data), .o_overlap_en(ovl));

    // system clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
            bad_count++;
        end
    endtask

    // strobe rise, bounded wait for the start pulse, then conversion time
    task automatic conv(output logic v);
        logic found;
        found = 1'b0;
        v = 1'b0;
        host_u.strobe(1'b1);
        for (int i = 0; i < 8 && !found; i++)
        begin
            @(posedge clk);
            #1 if (cfg_valid === 1'b1) v = 1'b1;
            found = (start === 1'b1);
        end
        if (!found)
        begin
            bad_count++;
            report_and_stop();
        end
        check(48'(chain_serial_output), 48'h0, "output during conversion");
        repeat (CONV + 2) @(posedge clk);
        #1 if (cfg_valid === 1'b1) v = 1'b1;
    endtask

    // end of frame: strobe low long enough for the next one
    task automatic frame_end(input string name);
        host_u.strobe(1'b0);
        repeat (4) @(posedge clk);
        #1;
        $display("test %s done", name);
    endtask

    // after reset: output low, overlap off, nothing received
    task automatic t_reset();
        check(48'(chain_serial_output), 48'h0, "output idle");
        check(48'(ovl), 48'h0, "overlap after reset");
        check(48'({cfg_valid, cmd, data}), 48'h0, "write outputs after reset");
        $display("test reset done");
    endtask

    // readout of this device and one upstream word
    task automatic t_read(input logic s, input logic [17:0] r, input logic [5:0] t,
                          input logic [23:0] up);
        int          len;
        logic        v;
        logic [47:0] got;
        logic [47:0] exp;
        len = s ? 24 : 18;
        st_en = s;
        res = r;
        stat = t;
        got = '0;
        exp = s ? {r, t} : 48'(r);
        exp = (exp << len) | (48'(up) & ((48'h1 << len) - 48'h1));
        conv(v);
        host_u.clocks(2 * len, 48'(up) << len);
        // sck rises with the strobe high restart the write count
        wr_tail = 8'h00;
        for (int k = 0; k < 2 * len; k++)
            got[2*len-1-k] = host_u.seen[k];
        check(got, exp, "chain readout");
        frame_end(s ? "read24" : "read18");
    endtask

    // register write with strobe low, then strobe rise delivers it
    task automatic t_write(input int n, input logic [23:0] b, input logic ev,
                           input logic [7:0] ec, input logic [7:0] ed, input logic eo);
        logic       v;
        logic [7:0] pipe;
        pipe = wr_tail;
        host_u.clocks(n, 48'(b));
        check(48'(host_u.seen[0]), 48'h0, "idle output before write");
        // expected pass-through: one byte of delay, carried over from the previous write
        for (int k = 1; k <= n; k++)
        begin
            pipe = {pipe[6:0], b[n-k]};
            check(48'(host_u.seen[k]), 48'(pipe[7]), "pass-through");
        end
        wr_tail = pipe;
        conv(v);
        check(48'(v), 48'(ev), "write pulse");
        check(48'({cmd, data}), 48'({ec, ed}), "write bytes");
        check(48'(ovl), 48'(eo), "overlap field");
        frame_end("write");
    endtask

    // main sequence
    initial
    begin
        bad_count = 0;
        total_checks = 0;
        rst_n = 1'b1;
        #1 rst_n = 1'b0;
        st_en = 1'b0;
        res = '0;
        stat = '0;
        wr_tail = 8'h00;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1 t_reset();
        t_read(1'b0, 18'h2a5c3, 6'h00, 24'h01f0f0);
        t_read(1'b1, 18'h15a5a, 6'h2d, 24'hc3a5f0);
        t_write(24, 24'h991402, 1'b1, 8'h14, 8'h02, 1'b1);
        t_write(16, 24'h0055ff, 1'b1, 8'h55, 8'hff, 1'b1);
        t_write(16, 24'h001400, 1'b1, 8'h14, 8'h00, 1'b0);
        t_read(1'b0, 18'h3ffff, 6'h00, 24'h000001);
        t_write(12, 24'h000fff, 1'b0, 8'h14, 8'h00, 1'b0);
        check(48'(host_u.skew), 48'h0, "output held over rise");
        report_and_stop();
    end
endmodule
